// >>> shared/power_pkg.sv
// Constants for the power mode and interrupt vectoring block
package power_pkg;
  // Interrupt sources, lowest index is highest priority
  localparam int NUM_SRC = 10;
  localparam int SRC_EI0 = 0;
  localparam int SRC_EI1 = 1;
  localparam int SRC_CSS = 2;
  localparam int SRC_SPI = 3;
  localparam int SRC_TIM16 = 4;
  localparam int SRC_ART_IC = 5;
  localparam int SRC_ART_OVF = 6;
  localparam int SRC_OA1 = 7;
  localparam int SRC_OA2 = 8;
  localparam int SRC_SCI = 9;
  localparam logic [3:0] SRC_NONE = 4'hF;

  // Vector pair base addresses
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_EI0 = 16'hFFFA;
  localparam logic [15:0] VEC_EI1 = 16'hFFF8;
  localparam logic [15:0] VEC_CSS = 16'hFFF6;
  localparam logic [15:0] VEC_SPI = 16'hFFF4;
  localparam logic [15:0] VEC_TIM16 = 16'hFFF2;
  localparam logic [15:0] VEC_ART_IC = 16'hFFF0;
  localparam logic [15:0] VEC_ART_OVF = 16'hFFEE;
  localparam logic [15:0] VEC_OA1 = 16'hFFEC;
  localparam logic [15:0] VEC_OA2 = 16'hFFEA;
  localparam logic [15:0] VEC_SCI = 16'hFFE4;

  // Sources allowed to end HALT (ei0, ei1, ART overflow, OA1, OA2)
  localparam logic [9:0] HALT_WAKE_MASK = 10'h1C3;

  // Oscillator divide ratios: run and the four slow settings
  localparam logic [5:0] DIV_RUN = 6'h02;
  localparam logic [5:0] DIV_SLOW_4 = 6'h04;
  localparam logic [5:0] DIV_SLOW_8 = 6'h08;
  localparam logic [5:0] DIV_SLOW_16 = 6'h10;
  localparam logic [5:0] DIV_SLOW_32 = 6'h20;

  // Oscillator stabilisation after HALT, in CPU cycles
  localparam int STARTUP_CPU_CYCLES = 4096;
  localparam logic [12:0] STARTUP_LAST =
    13'(STARTUP_CPU_CYCLES - 1);
  localparam logic [12:0] STARTUP_ZERO = 13'h0000;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_SLOW,
    MODE_WAIT,
    MODE_SLOW_WAIT,
    MODE_HALT,
    MODE_STARTUP
  } power_mode_t;
endpackage

// >>> src/clk_divider.sv
`timescale 1ns/1ps
// Oscillator divider producing the CPU and peripheral clock tick
module clk_divider
  import power_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  input  wire logic [5:0] ratio,
  output logic            tick
);
  logic [5:0] count;
  logic [5:0] active_ratio;
  wire        wrap = (count == active_ratio - 6'h01);

  // New ratio taken only at a period boundary, so no short pulse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 6'h00;
      active_ratio <= DIV_RUN;
      tick <= 1'b0;
    end else if (clk_en) begin
      tick <= wrap;
      if (wrap) begin
        count <= 6'h00;
        active_ratio <= ratio; // R18
      end else begin
        count <= count + 6'h01;
      end
    end
  end
endmodule

// >>> src/power_mode_ctrl.sv
`timescale 1ns/1ps
// Power mode sequencing and fixed-priority interrupt vectoring

// Notes on behaviour
// [R01] Each source has a fixed vector pair and fixed priority, reset highest.
// [R02] Serial causes share FFE4; SCI, SPI, timer, CSS never wake HALT.
// [R03] After reset the device runs with the oscillator divided by two.
// [R04] Slow mode divides the oscillator by 4, 8, 16 or 32.
// [R05] Wait instruction during slow mode gives slow-wait at the reduced rate.
// [R06] Wait stops only the CPU; peripherals keep their clock.
// [R07] Entering WAIT clears the interrupt mask bit.
// [R08] WAIT lasts until an interrupt or reset, then the routine is entered.
// [R09] Halt switches the oscillator off, stopping CPU and peripherals.
// [R10] HALT exit restarts the oscillator and waits 4096 CPU cycles first.
// [R11] HALT entry clears the mask; a pending interrupt wakes at once.
// [R12] Watchdog-in-halt option decides whether halt gives a watchdog reset.
// [R13] Interrupt entry pushes the condition code and sets the mask bit.
// [R14] Slow mode select and two divider select bits govern slow mode.
// [R15] Disabled or masked peripheral requests stay latched as pending.
// [R16] The software trap is always entered regardless of the mask bit.
// [R17] Highest fixed priority pending request is serviced first, others stay.
// [R18] Divider changes reach the CPU clock without glitches.
module power_mode_ctrl
  import power_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    clk_en,
  input  wire logic                    slow_mode_select,
  input  wire logic                    slow_divider_select_hi,
  input  wire logic                    slow_divider_select_lo,
  input  wire logic                    wait_for_interrupt_instr,
  input  wire logic                    halt_instr,
  input  wire logic                    trap_instr,
  input  wire logic                    mask_write,
  input  wire logic                    mask_write_value,
  input  wire logic                    cc_pop,
  input  wire logic                    cc_pop_mask,
  input  wire logic [NUM_SRC-1:0]      irq_event,
  input  wire logic [NUM_SRC-1:0]      irq_enable,
  input  wire logic [NUM_SRC-1:0]      irq_clear,
  input  wire logic                    watchdog_enabled,
  input  wire logic                    watchdog_in_halt_option,
  output power_pkg::power_mode_t       power_mode,
  output logic                         cpu_clk_en,
  output logic                         periph_clk_en,
  output logic                         osc_enable,
  output logic                         condition_code_mask,
  output logic                         cc_push,
  output logic                         vector_load,
  output logic [15:0]                  vector_addr,
  output logic [NUM_SRC-1:0]           irq_pending,
  output logic                         watchdog_reset_req
);
  import power_pkg::*;

  // Highest priority set bit of a request vector
  function automatic logic [3:0] first_src(input logic [NUM_SRC-1:0] req);
    logic [3:0] idx;
    idx = SRC_NONE;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Fixed vector of each source
  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    logic [15:0] v;
    case (idx)
      4'(SRC_EI0):     v = VEC_EI0;
      4'(SRC_EI1):     v = VEC_EI1;
      4'(SRC_CSS):     v = VEC_CSS;
      4'(SRC_SPI):     v = VEC_SPI;
      4'(SRC_TIM16):   v = VEC_TIM16;
      4'(SRC_ART_IC):  v = VEC_ART_IC;
      4'(SRC_ART_OVF): v = VEC_ART_OVF;
      4'(SRC_OA1):     v = VEC_OA1;
      4'(SRC_OA2):     v = VEC_OA2;
      4'(SRC_SCI):     v = VEC_SCI;
      default:         v = VEC_RESET;
    endcase
    return v;
  endfunction

  power_mode_t      next_mode;
  logic [12:0]      startup_count;
  logic [5:0]       div_ratio;
  logic             div_tick;
  logic             osc_on;

  // Divider select decode
  wire [1:0] div_code = {slow_divider_select_hi,
                         slow_divider_select_lo};
  wire [5:0] slow_ratio = (div_code == 2'b00) ? DIV_SLOW_4 :
                          (div_code == 2'b01) ? DIV_SLOW_8 :
                          (div_code == 2'b10) ? DIV_SLOW_16 :
                                                DIV_SLOW_32; // R04

  // Run ratio unless slow mode selected
  assign div_ratio = slow_mode_select ? slow_ratio : DIV_RUN; // R03 R14

  // Oscillator stopped only while halted; divider freezes with it
  assign osc_on = (power_mode != MODE_HALT); // R09

  clk_divider u_div (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en & osc_on),
    .ratio   (div_ratio),
    .tick    (div_tick)
  );

  // Request selection
  wire [NUM_SRC-1:0] ready_req = irq_pending & irq_enable;
  wire [NUM_SRC-1:0] halt_req = ready_req & HALT_WAKE_MASK; // R02
  wire [3:0]  best_src = first_src(ready_req); // R17
  wire [3:0]  best_halt = first_src(halt_req);
  wire        cpu_running = (power_mode == MODE_RUN) ||
                            (power_mode == MODE_SLOW);
  wire        in_wait = (power_mode == MODE_WAIT) ||
                        (power_mode == MODE_SLOW_WAIT);
  wire        startup_done = (power_mode == MODE_STARTUP) &&
                             div_tick && (startup_count == STARTUP_ZERO);
  wire        any_ready = (best_src != SRC_NONE);
  wire        take_trap = cpu_running && trap_instr; // R16
  wire        take_irq = !take_trap && any_ready &&
                         ((cpu_running && !condition_code_mask) ||
                          in_wait || startup_done); // R08
  wire        enter_wait = cpu_running && !take_trap && !take_irq &&
                           wait_for_interrupt_instr;
  wire        enter_halt = cpu_running && !take_trap && !take_irq &&
                           !wait_for_interrupt_instr && halt_instr;
  wire        halt_pending = (best_halt != SRC_NONE); // R02
  wire        take_any = take_trap || take_irq;
  wire [NUM_SRC-1:0] taken_onehot =
    take_irq ? (NUM_SRC'(1) << best_src) : {NUM_SRC{1'b0}};

  // Mode transitions
  always_comb begin
    next_mode = power_mode;
    case (power_mode)
      MODE_RUN, MODE_SLOW: begin
        if (enter_wait) begin
          next_mode = slow_mode_select ? MODE_SLOW_WAIT : MODE_WAIT; // R05
        end else if (enter_halt) begin
          // A request ready at entry leaves the oscillator running
          next_mode = any_ready ? power_mode : MODE_HALT; // R11
        end else begin
          next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN;
        end
      end
      MODE_WAIT, MODE_SLOW_WAIT: begin
        if (take_irq) begin
          next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN; // R08
        end
      end
      MODE_HALT: begin
        if (halt_pending) begin
          next_mode = MODE_STARTUP; // R10
        end
      end
      MODE_STARTUP: begin
        if (startup_done) begin
          next_mode = slow_mode_select ? MODE_SLOW : MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  // Mode register and stabilisation counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      power_mode <= MODE_RUN; // R03
      startup_count <= STARTUP_LAST;
    end else if (clk_en) begin
      power_mode <= next_mode;
      if (power_mode != MODE_STARTUP) begin
        startup_count <= STARTUP_LAST;
      end else if (div_tick) begin
        startup_count <= startup_count - 13'h0001; // R10
      end
    end
  end

  // Clock gating: CPU stops in wait, everything stops in halt
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_enable <= 1'b1;
    end else if (clk_en) begin
      cpu_clk_en <= div_tick && (next_mode == MODE_RUN ||
                                 next_mode == MODE_SLOW); // R06
      periph_clk_en <= div_tick && (next_mode != MODE_HALT) &&
                       (next_mode != MODE_STARTUP); // R06 R09
      osc_enable <= (next_mode != MODE_HALT); // R09 R10
    end
  end

  // Interrupt mask bit of the condition code
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      condition_code_mask <= 1'b1;
    end else if (clk_en) begin
      if (take_any) begin
        condition_code_mask <= 1'b1; // R13
      end else if (enter_wait || enter_halt) begin
        condition_code_mask <= 1'b0; // R07 R11
      end else if (cc_pop) begin
        condition_code_mask <= cc_pop_mask; // R13
      end else if (mask_write) begin
        condition_code_mask <= mask_write_value;
      end
    end
  end

  // Entry strobes; reset vector presented first after reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cc_push <= 1'b0;
      vector_load <= 1'b1;
      vector_addr <= VEC_RESET; // R01
    end else if (clk_en) begin
      cc_push <= take_any; // R13
      vector_load <= take_any;
      if (take_trap) begin
        vector_addr <= VEC_TRAP; // R16
      end else if (take_irq) begin
        vector_addr <= vector_of(best_src); // R01 R02
      end
    end
  end

  // Watchdog reset on halt when the option forbids watchdog in halt
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      watchdog_reset_req <= 1'b0;
    end else if (clk_en) begin
      watchdog_reset_req <= enter_halt && watchdog_enabled &&
                            !watchdog_in_halt_option; // R12
    end
  end

  // Pending latches: event set beats clear and beats servicing
  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_pend
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          irq_pending[s] <= 1'b0;
        end else if (clk_en) begin
          if (irq_event[s]) begin
            irq_pending[s] <= 1'b1; // R15
          end else if (irq_clear[s] || taken_onehot[s]) begin
            irq_pending[s] <= 1'b0; // R17
          end
        end
      end
    end
  endgenerate
endmodule

// >>> bench/power_checks_properties.sv
// Port-level assertions for the power mode and vectoring block
`timescale 1ns/1ps
module power_checks
  import power_pkg::*;
(
  input wire logic               mclk,
  input wire logic               reset_n,
  input wire logic               trap_instr,
  input wire logic               watchdog_enabled,
  input wire logic               watchdog_in_halt_option,
  input wire logic [NUM_SRC-1:0] irq_event,
  input power_pkg::power_mode_t  power_mode,
  input wire logic               cpu_clk_en,
  input wire logic               periph_clk_en,
  input wire logic               osc_enable,
  input wire logic               condition_code_mask,
  input wire logic               cc_push,
  input wire logic               vector_load,
  input wire logic [15:0]        vector_addr,
  input wire logic [NUM_SRC-1:0] irq_pending,
  input wire logic               watchdog_reset_req
);
  logic [13:0] start_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Cycles spent in startup; saturates so a stuck wake cannot wrap it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      start_cnt <= 14'h0000;
    else if (power_mode != MODE_STARTUP)
      start_cnt <= 14'h0000;
    else if (start_cnt != 14'h3FFF)
      start_cnt <= start_cnt + 14'h0001;
  end

  osc_halt_a: assert property (
    !osc_enable |-> power_mode == MODE_HALT) else $error("osc off");
  halt_quiet_a: assert property (
    $past(power_mode, 2) == MODE_HALT && power_mode == MODE_HALT
    |-> !cpu_clk_en && !periph_clk_en) else $error("clock in halt");
  push_mask_a: assert property (
    cc_push |-> vector_load && condition_code_mask) else $error("push");
  wait_mask_a: assert property (
    power_mode == MODE_WAIT && $past(power_mode) != MODE_WAIT
    |-> !condition_code_mask) else $error("mask in wait");
  wait_cpu_a: assert property (
    $past(power_mode, 2) == MODE_WAIT && power_mode == MODE_WAIT
    |-> !cpu_clk_en)
    else $error("cpu clock in wait");
  wdg_opt_a: assert property (
    watchdog_reset_req |-> $past(watchdog_enabled)
    && !$past(watchdog_in_halt_option)) else $error("watchdog req");
  halt_stay_a: assert property (
    power_mode == MODE_HALT && !(|(irq_pending & 10'h1C3)) && !(|irq_event)
    |=> power_mode == MODE_HALT) else $error("left halt");
  trap_vec_a: assert property (
    trap_instr && (power_mode == MODE_RUN || power_mode == MODE_SLOW)
    |=> vector_load && vector_addr == 16'hFFFC) else $error("trap");
  startup_len_a: assert property (
    power_mode == MODE_STARTUP ##1 power_mode != MODE_STARTUP
    |-> start_cnt >= 14'h1FF4) else $error("short startup");
endmodule

bind power_mode_ctrl power_checks i_checks (
  .mclk(mclk), .reset_n(reset_n), .trap_instr(trap_instr),
  .watchdog_enabled(watchdog_enabled),
  .watchdog_in_halt_option(watchdog_in_halt_option),
  .irq_event(irq_event), .power_mode(power_mode), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
  .condition_code_mask(condition_code_mask), .cc_push(cc_push),
  .vector_load(vector_load), .vector_addr(vector_addr),
  .irq_pending(irq_pending), .watchdog_reset_req(watchdog_reset_req)
);

// >>> bench/core_model.sv
// Core-side model: records every interrupt entry the core performs
`timescale 1ns/1ps
module core_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        cc_push,
  input  wire logic        vector_load,
  input  wire logic [15:0] vector_addr,
  output logic [7:0]       entries,
  output logic [15:0]      last_vec
);
  // Only a push is an entry; the bare load after reset is not counted
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      entries  <= 8'h00;
      last_vec <= 16'h0000;
    end else if (cc_push && vector_load) begin
      entries  <= entries + 8'h01;
      last_vec <= vector_addr;
    end
  end
endmodule

// >>> bench/tb_power_mode_ctrl.sv
// Self-checking bench for the power mode and vectoring block
`timescale 1ns/1ps
module tb_power_mode_ctrl;
  import power_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b0, slow_mode_select = 1'b0;
  logic slow_divider_select_hi = 1'b0, slow_divider_select_lo = 1'b0;
  logic wait_for_interrupt_instr = 1'b0, halt_instr = 1'b0;
  logic trap_instr = 1'b0, mask_write = 1'b0, mask_write_value = 1'b0;
  logic cc_pop = 1'b0, cc_pop_mask = 1'b0, watchdog_enabled = 1'b0;
  logic watchdog_in_halt_option = 1'b0;
  logic [NUM_SRC-1:0] irq_event = '0, irq_clear = '0, irq_pending;
  logic [NUM_SRC-1:0] irq_enable = '1;
  power_mode_t power_mode;
  logic cpu_clk_en, periph_clk_en, osc_enable, condition_code_mask;
  logic cc_push, vector_load, watchdog_reset_req;
  logic [15:0] vector_addr, last_vec;
  logic [7:0] entries;
  int error_cnt = 0, n_tests = 0, cyc = 0;

  power_mode_ctrl i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
    .slow_mode_select(slow_mode_select),
    .slow_divider_select_hi(slow_divider_select_hi),
    .slow_divider_select_lo(slow_divider_select_lo),
    .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .halt_instr(halt_instr), .trap_instr(trap_instr),
    .mask_write(mask_write), .mask_write_value(mask_write_value),
    .cc_pop(cc_pop), .cc_pop_mask(cc_pop_mask), .irq_event(irq_event),
    .irq_enable(irq_enable), .irq_clear(irq_clear),
    .watchdog_enabled(watchdog_enabled),
    .watchdog_in_halt_option(watchdog_in_halt_option),
    .power_mode(power_mode), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
    .condition_code_mask(condition_code_mask), .cc_push(cc_push),
    .vector_load(vector_load), .vector_addr(vector_addr),
    .irq_pending(irq_pending), .watchdog_reset_req(watchdog_reset_req));
  core_model i_core (.mclk(mclk), .reset_n(reset_n), .cc_push(cc_push),
    .vector_load(vector_load), .vector_addr(vector_addr),
    .entries(entries), .last_vec(last_vec));

  // 10 MHz clock and a cycle ceiling against hangs
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tk(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One-cycle pulse: 0 wait, 1 halt, 2 trap, 3 pop restoring the cc_pop_mask value
  task automatic instr(int k);
    @(posedge mclk);
    {cc_pop, trap_instr, halt_instr, wait_for_interrupt_instr} <= 4'h1 << k;
    @(posedge mclk);
    {cc_pop, trap_instr, halt_instr, wait_for_interrupt_instr} <= 4'h0;
  endtask

  task automatic fire(logic [NUM_SRC-1:0] v);
    @(posedge mclk);
    irq_event <= v;
    @(posedge mclk);
    irq_event <= '0;
  endtask

  task automatic set_mask(logic v);
    @(posedge mclk);
    mask_write <= 1'b1;
    mask_write_value <= v;
    @(posedge mclk);
    mask_write <= 1'b0;
  endtask

  // Bounded wait for the core to take an entry, then check its vector
  task automatic expect_vec(logic [15:0] v, output int n);
    logic [7:0] e0;
    e0 = entries;
    n = 0;
    while (entries === e0 && n < 9000) begin
      tk(1);
      n++;
    end
    chk("vector", v, last_vec);
  endtask

  task automatic count_clk(int n, output int c, output int p, output int w);
    {c, p, w} = '0;
    repeat (n) begin
      tk(1);
      c += int'(cpu_clk_en === 1'b1);
      p += int'(periph_clk_en === 1'b1);
      w += int'(watchdog_reset_req === 1'b1);
    end
  endtask

  // Run rate then each slow divider, counted over a fixed window
  task automatic t_rates();
    int c, p, w;
    for (int s = 0; s < 5; s++) begin
      @(posedge mclk);
      slow_mode_select <= (s != 0);
      {slow_divider_select_hi, slow_divider_select_lo} <= 2'(s - 1);
      tk(70);
      count_clk(128, c, p, w);
      chk("cpu ticks", 16'(64 >> s), 16'(c));
      chk("periph ticks", 16'(64 >> s), 16'(p));
      chk("mode", 16'(s != 0 ? MODE_SLOW : MODE_RUN), 16'(power_mode));
    end
    slow_mode_select <= 1'b0;
    // Later slow tests expect the divide-by-4 setting
    {slow_divider_select_hi, slow_divider_select_lo} <= 2'b00;
  endtask

  task automatic t_vectors();
    logic [15:0] vt [NUM_SRC] = '{16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4,
      16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA, 16'hFFE4};
    int n;
    for (int i = 0; i < NUM_SRC; i++) begin
      set_mask(1'b0);
      fire(10'(1 << i));
      expect_vec(vt[i], n);
      chk("mask", 16'h0001, 16'(condition_code_mask));
      chk("pending", 16'h0000, 16'(irq_pending));
    end
    instr(3);
    tk(2);
    chk("mask", 16'h0000, 16'(condition_code_mask));
    // Pop with the mask set restores a set mask
    cc_pop_mask <= 1'b1;
    instr(3);
    tk(2);
    chk("mask", 16'h0001, 16'(condition_code_mask));
    cc_pop_mask <= 1'b0;
  endtask

  // Masked requests wait; trap ignores mask; priority order on release
  task automatic t_prio();
    int n;
    set_mask(1'b1);
    fire(10'h204);
    tk(3);
    chk("pending", 16'h0204, 16'(irq_pending));
    instr(2);
    expect_vec(16'hFFFC, n);
    instr(3);
    expect_vec(16'hFFF6, n);
    chk("pending", 16'h0200, 16'(irq_pending));
    instr(3);
    expect_vec(16'hFFE4, n);
    fire(10'h008);
    irq_clear <= 10'h008;
    @(posedge mclk);
    irq_clear <= '0;
    tk(2);
    chk("pending", 16'h0000, 16'(irq_pending));
    instr(3);
  endtask

  task automatic t_wait(logic slow);
    int c, p, w, n;
    @(posedge mclk);
    slow_mode_select <= slow;
    tk(70);
    set_mask(1'b1);
    instr(0);
    tk(2);
    chk("mode", 16'(slow ? MODE_SLOW_WAIT : MODE_WAIT), 16'(power_mode));
    chk("mask", 16'h0000, 16'(condition_code_mask));
    count_clk(64, c, p, w);
    chk("cpu ticks", 16'h0000, 16'(c));
    chk("periph ticks", 16'(32 >> slow), 16'(p));
    fire(10'h040);
    expect_vec(16'hFFEE, n);
    tk(2);
    chk("mode", 16'(slow ? MODE_SLOW : MODE_RUN), 16'(power_mode));
    instr(3);
    slow_mode_select <= 1'b0;
  endtask

  task automatic t_halt();
    int c, p, w, n;
    @(posedge mclk);
    watchdog_enabled <= 1'b1;
    instr(1);
    #1;
    // Request stands only in the cycle after the halt edge
    chk("watchdog req", 16'h0001, 16'(watchdog_reset_req));
    count_clk(4, c, p, w);
    chk("watchdog once", 16'h0000, 16'(w));
    count_clk(30, c, p, w);
    chk("halt ticks", 16'h0000, 16'(c + p));
    chk("osc", 16'h0000, 16'(osc_enable));
    fire(10'h008);
    tk(10);
    chk("mode", 16'(MODE_HALT), 16'(power_mode));
    fire(10'h002);
    expect_vec(16'hFFF8, n);
    chk("startup", 16'h0001, 16'(n > 8180 && n < 8230));
    watchdog_in_halt_option <= 1'b1;
    instr(1);
    expect_vec(16'hFFF4, n);
    chk("wake at once", 16'h0001, 16'(n < 6 && osc_enable === 1'b1));
    instr(3);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("mode", 16'(MODE_RUN), 16'(power_mode));
    chk("vector", 16'hFFFE, vector_addr);
    t_rates();
    t_vectors();
    t_prio();
    t_wait(1'b0);
    t_wait(1'b1);
    t_halt();
    close_out();
  end
endmodule
